// ===== verilog/sbd_requester.sv
// requester end: processor side of the data phase
// assumes one shared clock; the target owns the transaction_n_a line
`timescale 1ns/1ps

// how a write burst runs, as seen from this end
// - the user raises wr_req for one cycle while wr_busy is low
// - the word is latched and the sequencer waits for a free bus
// - a free bus means the shared busy line is high (released)
// - busy still low from another agent keeps us waiting, unbounded
// - once free, four beats go out on four consecutive cycles
// - beats alternate word and complement, so both encodings get used, except in a group with exactly 8 ones
// - busy, valid and the output enable fall and rise together
// - each 16-bit group is sent so that at most half its lines are low
// - a group that would pull more than half low goes out flipped
// - the flipped state of a group is shown on its low-active flag
// - parity of each group is taken over the levels on the wire
// - parity and flags come from this end only while it drives data
//
// how a received burst is seen
// - beats are taken only while another agent holds valid low
// - our own beats are ignored: the output enable tells them apart
// - each group is put back to true data using its flag
// - rx_valid_q pulses one cycle after each beat, with the data
// - a parity mismatch on any beat sets the sticky parity flag
//
// completion flags
// - the transaction_n_a line belongs to the target; this end only watches it
// - deferred_q and parity_err_q stay set until the next write
// - taking a new write clears both, but a transaction_n_a in that same cycle
//   still sets deferred_q, so no transaction_n_a is ever lost
//
// limitations
// - arbitration is outside: two ends that both see a free bus in one
//   cycle would both drive; the surroundings must prevent that

module sbd_requester
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // bus side
  sbd_bus_if.requester     bus,
  // user side: write burst request
  input  wire logic        wr_req,
  input  wire logic [63:0] wr_data,
  output logic             wr_busy,
  // user side: received data and completion
  output logic [63:0]      rx_data_q,
  output logic             rx_valid_q,
  output logic             deferred_q,
  output logic             parity_err_q
);
  import sbd_pkg::*;

  // burst sequencer state
  sbd_state_t       state_q, state_d;
  logic [2:0]       beat_q, beat_d;
  logic [63:0]      word_q, word_d;
  // completion flags and receive registers, next values
  logic             deferred_d;
  logic             perr_d;
  logic [63:0]      rx_d;
  logic             rxv_d;
  // wire-side encode of the word being driven
  logic [63:0]      enc_data;
  logic [GRP_N-1:0] enc_dbi;
  logic [GRP_N-1:0] enc_dp;
  // wire-side decode of what another agent drives
  logic [63:0]      rx_true;
  logic [GRP_N-1:0] rx_dp_bad;

  // per-group inversion, parity encode, decode and parity check
  // every group is handled alike, so one loop covers all four
  genvar g;
  generate
    for (g = 0; g < GRP_N; g++)
    begin : g_grp
      logic [GRP_W-1:0] grp;
      logic [GRP_W-1:0] lin;
      logic [GRP_W-1:0] wire_grp;
      assign grp = word_q[g*GRP_W +: GRP_W];
      // a one in the data pulls its line low; count those lows
      // low-active flag: 0 means the group is inverted
      assign enc_dbi[g] = !($countones(grp) > HALF_GRP);
      // plain groups go out complemented, flipped groups as they are
      assign lin = enc_dbi[g] ? ~grp : grp;
      assign enc_data[g*GRP_W +: GRP_W] = lin;
      // parity covers the group exactly as it stands on the wire
      assign enc_dp[g] = ^lin;
      // receive side: undo the complement or the inversion
      assign wire_grp = bus.data_n[g*GRP_W +: GRP_W];
      assign rx_true[g*GRP_W +: GRP_W] = bus.data_inversion_flag_n[g]
                                       ? ~wire_grp : wire_grp;
      assign rx_dp_bad[g] = (^wire_grp) != bus.data_parity_n[g];
    end
  endgenerate

  // write burst sequencer; waits for the bus to be released
  always_comb
  begin
    state_d = state_q;
    beat_d  = beat_q;
    word_d  = word_q;
    case (state_q)
      // a request is taken only from idle; later ones are ignored
      SBD_IDLE:
        if (wr_req)
        begin
          word_d  = wr_data;
          state_d = SBD_WAIT;
        end
      SBD_WAIT:
        // a stale busy from another agent holds us off
        if (bus.data_bus_busy_n)
        begin
          state_d = SBD_DRIVE;
          beat_d  = 3'h0;
        end
      // four beats: word, complement, word, complement
      SBD_DRIVE:
      begin
        beat_d = beat_q + 3'h1;
        word_d = ~word_q;        // each beat differs from the last
        if (beat_q == LAST_BEAT)
          state_d = SBD_IDLE;
      end
      default: state_d = SBD_IDLE;
    endcase
  end

  // completion flags: sticky until the next write is taken
  // a transaction_n_a in the same cycle as the clear still wins
  always_comb
  begin
    perr_d     = parity_err_q;
    deferred_d = deferred_q;
    if (wr_req && state_q == SBD_IDLE)
    begin
      deferred_d = 1'b0;
      perr_d     = 1'b0;
    end
    if (!bus.transaction_n_a)
      deferred_d = 1'b1;
    // parity is judged only on beats that another agent drives
    if (!bus.data_valid_n && bus.req_oe_n && (|rx_dp_bad))
      perr_d = 1'b1;
  end

  // receive data: only while another agent owns the bus
  // the last word is kept, so the user may read it late
  always_comb
  begin
    rx_d  = rx_data_q;
    rxv_d = 1'b0;
    if (!bus.data_valid_n && bus.req_oe_n)
    begin
      rx_d  = rx_true;
      rxv_d = 1'b1;
    end
  end

  // registers only; reset leaves every bus line released
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q      <= SBD_IDLE;
      beat_q       <= 3'h0;
      word_q       <= 64'h0;
      rx_data_q    <= 64'h0;
      rx_valid_q   <= 1'b0;
      deferred_q   <= 1'b0;
      parity_err_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      beat_q       <= beat_d;
      word_q       <= word_d;
      rx_data_q    <= rx_d;
      rx_valid_q   <= rxv_d;
      deferred_q   <= deferred_d;
      parity_err_q <= perr_d;
    end
  end

  // bus drive, all from the data owner; released lines sit high
  // busy and valid share one span, so a watcher of either sees the
  // whole burst and no agent can slip in between two beats
  assign bus.req_oe_n         = (state_q != SBD_DRIVE);
  assign bus.req_busy_n       = (state_q != SBD_DRIVE);
  assign bus.req_data_valid_n = (state_q != SBD_DRIVE);
  assign bus.req_data_n       = enc_data;
  assign bus.req_dbi_n        = enc_dbi;
  assign bus.req_dp_n         = enc_dp;
  assign wr_busy              = (state_q != SBD_IDLE);
endmodule // sbd_requester

// ===== verilog/sbd_pkg.sv
// package for the system bus data phase control block
// shared by the requester end, the target end and the joining interface
package sbd_pkg;
  localparam int DATA_W   = 64;
  localparam int GRP_W    = 16;
  localparam int GRP_N    = 4;
  localparam int HALF_GRP = 8;   // more than this many lows triggers inversion
  localparam int BEATS    = 4;   // data transfers per transaction
  localparam logic [2:0] LAST_BEAT = 3'h3;
  localparam logic [3:0] ALL_HIGH4 = 4'hF;

  typedef enum logic [1:0] {
    SBD_IDLE = 2'b00,
    SBD_WAIT = 2'b01,
    SBD_DRIVE = 2'b10
  } sbd_state_t;
endpackage

// ===== verilog/sbd_bus_if.sv
// interface joining the requester and target ends of the data bus
// active-low shared lines; wire level resolved in this interface
`timescale 1ns/1ps
interface sbd_bus_if;
  import sbd_pkg::*;
  // requester drive
  logic [DATA_W-1:0] req_data_n;
  logic [GRP_N-1:0]  req_dp_n;
  logic [GRP_N-1:0]  req_dbi_n;
  logic              req_data_valid_n;
  logic              req_busy_n;
  logic              req_oe_n;
  // target drive
  logic [DATA_W-1:0] tgt_data_n;
  logic [GRP_N-1:0]  tgt_dp_n;
  logic [GRP_N-1:0]  tgt_dbi_n;
  logic              tgt_data_valid_n;
  logic              tgt_busy_n;
  logic              tgt_oe_n;
  logic              transaction_n_a;
  // wired-and view of the shared bus
  logic [DATA_W-1:0] data_n;
  logic [GRP_N-1:0]  data_parity_n;
  logic [GRP_N-1:0]  data_inversion_flag_n;
  logic              data_valid_n;
  logic              data_bus_busy_n;
  assign data_n = (req_oe_n ? '1 : req_data_n) & (tgt_oe_n ? '1 : tgt_data_n);
  assign data_parity_n = (req_oe_n ? ALL_HIGH4 : req_dp_n)
                       & (tgt_oe_n ? ALL_HIGH4 : tgt_dp_n);
  assign data_inversion_flag_n = (req_oe_n ? ALL_HIGH4 : req_dbi_n)
                               & (tgt_oe_n ? ALL_HIGH4 : tgt_dbi_n);
  assign data_valid_n = req_data_valid_n & tgt_data_valid_n;
  assign data_bus_busy_n = req_busy_n & tgt_busy_n;

  modport requester (
    output req_data_n, req_dp_n, req_dbi_n, req_data_valid_n, req_busy_n,
           req_oe_n,
    input  data_n, data_parity_n, data_inversion_flag_n, data_valid_n,
           data_bus_busy_n, transaction_n_a
  );
  modport target (
    output tgt_data_n, tgt_dp_n, tgt_dbi_n, tgt_data_valid_n, tgt_busy_n,
           tgt_oe_n, transaction_n_a,
    input  data_n, data_parity_n, data_inversion_flag_n, data_valid_n,
           data_bus_busy_n
  );
endinterface // sbd_bus_if

// ===== verilog/sbd_target.sv
// target end: addressed agent, answers with transaction_n_a and may drive data
// assumes one shared clock and that the requester keeps its own rules
`timescale 1ns/1ps
module sbd_target
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // bus side
  sbd_bus_if.target        bus,
  // user side
  input  wire logic        send_req,
  input  wire logic        transaction_n_a_req,
  input  wire logic [63:0] send_data,
  output logic             send_busy,
  output logic [63:0]      rx_data_q,
  output logic             rx_valid_q
);
  import sbd_pkg::*;

  sbd_state_t       state_q, state_d;
  logic [2:0]       beat_q, beat_d;
  logic [63:0]      word_q, word_d;
  logic             transaction_n_a_q, transaction_n_a_d;
  logic [63:0]      enc_data;
  logic [GRP_N-1:0] enc_dbi;
  logic [GRP_N-1:0] enc_dp;
  logic [63:0]      rx_d;
  logic             rxv_d;

  // per-group inversion and parity, driver side
  genvar g;
  generate
    for (g = 0; g < GRP_N; g++)
    begin : g_enc
      logic [GRP_W-1:0] grp;
      logic [GRP_W-1:0] lin;
      assign grp = word_q[g*GRP_W +: GRP_W];
      assign enc_dbi[g] = !($countones(grp) > HALF_GRP);
      assign lin = enc_dbi[g] ? ~grp : grp; // plain groups go complemented
      assign enc_data[g*GRP_W +: GRP_W] = lin;
      assign enc_dp[g] = ^lin;
    end
  endgenerate

  // next state: drive only once the bus is released
  always_comb
  begin
    state_d = state_q;
    beat_d  = beat_q;
    word_d  = word_q;
    transaction_n_a_d = transaction_n_a_q;
    case (state_q)
      SBD_IDLE:
      begin
        transaction_n_a_d = transaction_n_a_req;
        if (send_req)
        begin
          word_d  = send_data;
          state_d = SBD_WAIT;
        end
      end
      SBD_WAIT:
        if (bus.data_bus_busy_n)
        begin
          state_d = SBD_DRIVE;
          beat_d  = 3'h0;
        end
      SBD_DRIVE:
      begin
        beat_d = beat_q + 3'h1;
        word_d = ~word_q;        // simple distinct beat pattern
        if (beat_q == LAST_BEAT)
          state_d = SBD_IDLE;
      end
      default: state_d = SBD_IDLE;
    endcase
  end

  // receive side decodes inversion so user sees true data
  always_comb
  begin
    rx_d  = rx_data_q;
    rxv_d = 1'b0;
    if (!bus.data_valid_n && bus.tgt_oe_n)
    begin
      for (int i = 0; i < GRP_N; i++)
        rx_d[i*GRP_W +: GRP_W] = bus.data_inversion_flag_n[i]
          ? ~bus.data_n[i*GRP_W +: GRP_W] : bus.data_n[i*GRP_W +: GRP_W];
      rxv_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q    <= SBD_IDLE;
      beat_q     <= 3'h0;
      word_q     <= 64'h0;
      transaction_n_a_q    <= 1'b0;
      rx_data_q  <= 64'h0;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      beat_q     <= beat_d;
      word_q     <= word_d;
      transaction_n_a_q    <= transaction_n_a_d;
      rx_data_q  <= rx_d;
      rx_valid_q <= rxv_d;
    end
  end

  // bus drive: busy, valid, parity from the data owner
  assign bus.tgt_oe_n         = (state_q != SBD_DRIVE);
  assign bus.tgt_busy_n       = (state_q != SBD_DRIVE);
  assign bus.tgt_data_valid_n = (state_q != SBD_DRIVE);
  assign bus.tgt_data_n       = enc_data;
  assign bus.tgt_dbi_n        = enc_dbi;
  assign bus.tgt_dp_n         = enc_dp;
  assign bus.transaction_n_a  = !transaction_n_a_q;
  assign send_busy            = (state_q != SBD_IDLE);
endmodule // sbd_target

// ===== testbench/sbd_monitor.sv
// checker for the data phase of the shared system bus
// takes the joined interface signals; one clock, sync reset
`timescale 1ns/1ps
module sbd_monitor
(
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      rst,
  // shared wire view
  input wire logic [sbd_pkg::DATA_W-1:0] data_n,
  input wire logic [sbd_pkg::GRP_N-1:0]  data_parity_n,
  input wire logic                      data_valid_n,
  input wire logic                      data_bus_busy_n,
  input wire logic                      transaction_n_a,
  // per-end drive controls
  input wire logic                      req_oe_n,
  input wire logic                      tgt_oe_n,
  input wire logic                      req_busy_n,
  input wire logic                      tgt_busy_n
);
  import sbd_pkg::*;
  logic [GRP_N-1:0] par_ok;
  logic [GRP_N-1:0] inv_ok;
  // per-group parity and electrical-low count, rebuilt from the wire
  always_comb
  begin
    for (int g = 0; g < GRP_N; g++)
    begin
      par_ok[g] = (data_parity_n[g] == ^data_n[g*GRP_W +: GRP_W]);
      inv_ok[g] = ($countones(~data_n[g*GRP_W +: GRP_W]) <= HALF_GRP);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  req_busy_drive_a: assert property ($fell(req_oe_n) |->
    !req_busy_n [*4] ##1 req_busy_n) else $error("requester busy span");
  tgt_busy_drive_a: assert property ($fell(tgt_oe_n) |->
    !tgt_busy_n [*4] ##1 tgt_busy_n) else $error("target busy span");
  start_when_free_a: assert property (($fell(req_oe_n) ||
    $fell(tgt_oe_n)) |-> $past(data_bus_busy_n)) else $error("bus taken");
  single_driver_a: assert property (req_oe_n || tgt_oe_n)
    else $error("two drivers");
  parity_match_a: assert property (!data_valid_n |-> &par_ok)
    else $error("parity wrong");
  inversion_rule_a: assert property (!data_valid_n |-> &inv_ok)
    else $error("group left uninverted");
  valid_span_a: assert property ($fell(data_valid_n) |->
    !data_valid_n [*4] ##1 data_valid_n) else $error("valid span");
  valid_busy_a: assert property (data_valid_n == data_bus_busy_n)
    else $error("valid and busy differ");
  cover property ($fell(req_oe_n));
  cover property ($fell(tgt_oe_n));
  cover property (!transaction_n_a);
endmodule // sbd_monitor

// ===== testbench/testbench.sv
// self-checking bench: both ends joined by the bus interface
// 100 MHz clock; inputs change 1 ns after each rising edge
`timescale 1ns/1ps
module testbench;
  import sbd_pkg::*;
  logic        sys_clk = 0, rst = 1;
  logic        wr_req = 0, send_req = 0, transaction_n_a_req = 0;
  logic [63:0] wr_data = '0, send_data = '0, rq_d, tg_d;
  logic        wr_busy, send_busy, rq_v, tg_v, dfr, perr;
  int          n_errors = 0, total_checks = 0;
  sbd_bus_if b ();
  // free-running clock
  always #5 sys_clk = ~sys_clk;
  sbd_requester sbd_requester_i (.sys_clk(sys_clk), .rst(rst), .bus(b),
    .wr_req(wr_req), .wr_data(wr_data), .wr_busy(wr_busy),
    .rx_data_q(rq_d), .rx_valid_q(rq_v), .deferred_q(dfr),
    .parity_err_q(perr));
  sbd_target sbd_target_i (.sys_clk(sys_clk), .rst(rst), .bus(b),
    .send_req(send_req), .transaction_n_a_req(transaction_n_a_req), .send_data(send_data),
    .send_busy(send_busy), .rx_data_q(tg_d), .rx_valid_q(tg_v));
  sbd_monitor sbd_monitor_i (.sys_clk(sys_clk), .rst(rst),
    .data_n(b.data_n), .data_parity_n(b.data_parity_n),
    .data_valid_n(b.data_valid_n), .data_bus_busy_n(b.data_bus_busy_n),
    .transaction_n_a(b.transaction_n_a), .req_oe_n(b.req_oe_n),
    .tgt_oe_n(b.tgt_oe_n), .req_busy_n(b.req_busy_n),
    .tgt_busy_n(b.tgt_busy_n));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle request from either end; the idle end keeps quiet
  task automatic go(input bit tgt, input logic [63:0] w);
    @(posedge sys_clk);
    #1;
    send_req = tgt;
    wr_req = !tgt;
    send_data = w;
    wr_data = w;
    @(posedge sys_clk);
    #1;
    send_req = 0;
    wr_req = 0;
  endtask
  // four received beats, word and complement in turn
  task automatic beats(input bit to_req, input logic [63:0] w);
    int n;
    for (int k = 0; k < BEATS; k++)
    begin
      n = 0;
      do begin @(posedge sys_clk); #1; n++; end
      while ((to_req ? rq_v : tg_v) !== 1'b1 && n < 20);
      chk(to_req ? rq_v : tg_v, 1);
      chk(to_req ? rq_d : tg_d, k[0] ? ~w : w);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few dozen cycles the tests need
  initial
  begin
    #100000;
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 0;
    chk(b.data_bus_busy_n, 1);
    chk(b.transaction_n_a, 1);
    go(0, 64'h01FF_00FF_FFFF_0000);
    @(posedge sys_clk);
    #1;
    chk(b.data_bus_busy_n, 0);
    chk(b.data_inversion_flag_n, 4'h5);
    beats(0, 64'h01FF_00FF_FFFF_0000);
    chk(b.data_bus_busy_n, 1);
    chk({dfr, perr}, 0);
    $display("test 1 done: requester write");
    transaction_n_a_req = 1;
    go(1, 64'h1234_5678_9ABC_DEF0);
    beats(1, 64'h1234_5678_9ABC_DEF0);
    transaction_n_a_req = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(dfr, 1);
    chk(perr, 0);
    $display("test 2 done: deferred target send");
    go(0, 64'hFFFF_FF00_0001_8000);
    beats(0, 64'hFFFF_FF00_0001_8000);
    chk(dfr, 0);
    go(1, 64'h0000_FFFF_00FF_7FFF);
    beats(1, 64'h0000_FFFF_00FF_7FFF);
    chk(perr, 0);
    $display("test 3 done: back to back");
    conclude();
  end
endmodule // testbench
